/* File: rtl/sspspi_pkg.sv */
// package for the synchronous serial port in spi mode: offsets, fields, reset values
// assumes an apb slave with 32-bit data and one register per aligned word
// Notes on behaviour
// - master, sample phase set: sample at end
// - master, sample phase clear: sample at middle
// - slave overrun sets overflow flag; software clears
// - data/address flag meaningful only in two-wire mode
package sspspi_pkg;
  // byte addresses of the registers
  localparam logic [7:0] SSPSPI_CTRL_OFS = 8'h14;  // serial_port_control
  localparam logic [7:0] SSPSPI_STAT_OFS = 8'h94;  // serial_port_status
  localparam logic [7:0] SSPSPI_BUF_OFS  = 8'h98;  // serial_buffer
  localparam logic [7:0] SSPSPI_IRQS_OFS = 8'h9c;  // interrupt status, read clears
  localparam logic [7:0] SSPSPI_IRQM_OFS = 8'ha0;  // interrupt mask
  // reset values
  localparam logic [7:0] SSPSPI_CTRL_RST = 8'h00;
  localparam logic [7:0] SSPSPI_STAT_RST = 8'h00;
  // control fields
  localparam int SSPSPI_C_COLL = 7;  // write_collision_flag
  localparam int SSPSPI_C_OVF  = 6;  // receive_overflow_flag
  localparam int SSPSPI_C_EN   = 5;  // port_enable_bit
  localparam int SSPSPI_C_POL  = 4;  // clock_idle_polarity
  // status fields
  localparam int SSPSPI_S_PHASE = 7;  // input_sample_phase
  localparam int SSPSPI_S_CKE   = 6;  // clock edge select
  localparam int SSPSPI_S_DA    = 5;  // data/address, always 0 outside two-wire mode
  localparam int SSPSPI_S_FULL  = 0;  // buffer_full_flag
  // interrupt status bits
  localparam int SSPSPI_I_DONE = 0;  // byte complete
  localparam int SSPSPI_I_OVF  = 1;  // receive overflow
  localparam int SSPSPI_I_COLL = 2;  // write collision
  localparam logic [2:0] SSPSPI_IRQ_RST = 3'h0;
  // master clock dividers in pclk cycles per half bit (fosc/4 = 2 pclk cycles per half bit)
  localparam logic [7:0] SSPSPI_HALF_DIV4  = 8'h02;
  localparam logic [7:0] SSPSPI_HALF_DIV16 = 8'h08;
  localparam logic [7:0] SSPSPI_HALF_DIV64 = 8'h20;
  localparam logic [3:0] SSPSPI_BITS = 4'h8;
  // port_mode_select encodings
  localparam logic [3:0] SSPSPI_M_DIV4  = 4'h0;
  localparam logic [3:0] SSPSPI_M_DIV16 = 4'h1;
  localparam logic [3:0] SSPSPI_M_DIV64 = 4'h2;
  localparam logic [3:0] SSPSPI_M_TMR   = 4'h3;
  localparam logic [3:0] SSPSPI_M_SLVSS = 4'h4;
  localparam logic [3:0] SSPSPI_M_SLV   = 4'h5;
endpackage

/* File: rtl/sspspi_sync.sv */
// two flip-flop synchroniser for pins entering the pclk domain
// assumes inputs are asynchronous to pclk
`timescale 1ns/1ps
module sspspi_sync #(
  parameter int W = 1  // number of bits
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins and synchronised copies
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;  // first stage, read only by the second
  // two stages in series
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* File: rtl/sspspi_port.sv */
// synchronous serial port, spi mode: apb registers, shifter, interrupt
// assumes pins come from another domain; slave sck far slower than pclk
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module sspspi_port (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial pins
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  input  wire logic        ss_n,
  input  wire logic        tmr_match,  // timer match pulse from same domain
  // interrupt
  output logic             irq
);
  typedef struct packed {
    logic [7:0]  ctrl;    // serial_port_control
    logic [7:0]  stat;    // serial_port_status (phase, edge writable; full flag by hw)
    logic [7:0]  buf_q;   // serial_buffer
    logic [7:0]  sh;      // serial_shift_register
    logic [3:0]  cnt;     // bits left
    logic        busy;    // byte in flight
    logic        phase;   // master: 0 first half of bit, 1 second half
    logic [7:0]  div;     // half-bit timer
    logic        sck_q;   // master clock level
    logic        sdo_q;
    logic        samp;    // sampled data bit awaiting shift
    logic        sck_d;   // previous synchronised slave clock
    logic [2:0]  ists;    // interrupt status
    logic [2:0]  imsk;    // interrupt mask
    logic [31:0] rd;
    logic        rdy;
    logic        err;
    logic        irq;
    logic        sck_en;  // clock pin driven, master modes only
    logic        sdo_en;  // data pin driven while the port is enabled
  } sspspi_st_t;
  sspspi_st_t s_r, s_nxt;
  logic [2:0] pin_s;  // synchronised sck, sdi, ss_n
  sspspi_sync #(.W(3)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({sck_in, sdi, ss_n}),
    .q       (pin_s)
  );
  // half-bit period of the selected master clock
  function automatic logic [7:0] half_of(input logic [3:0] m);
    case (m)
      sspspi_pkg::SSPSPI_M_DIV16: half_of = sspspi_pkg::SSPSPI_HALF_DIV16;
      sspspi_pkg::SSPSPI_M_DIV64: half_of = sspspi_pkg::SSPSPI_HALF_DIV64;
      default:                    half_of = sspspi_pkg::SSPSPI_HALF_DIV4;
    endcase
  endfunction
  // register and shifter next state
  always_comb begin
    logic       en, master, slave, acc, wr, rd, pol, cke, late;
    logic       sck_e, lead, trail, launch_e, capture_e, done, tick;
    logic [3:0] mode;
    // defaults first, so no branch below can leave a latch behind
    tick = 1'b0;
    sck_e = 1'b0;
    lead = 1'b0;
    trail = 1'b0;
    launch_e = 1'b0;
    capture_e = 1'b0;
    s_nxt = s_r;
    mode = s_r.ctrl[3:0];
    en = s_r.ctrl[sspspi_pkg::SSPSPI_C_EN];
    master = en && (mode <= sspspi_pkg::SSPSPI_M_TMR);
    slave = en && (mode == sspspi_pkg::SSPSPI_M_SLVSS || mode == sspspi_pkg::SSPSPI_M_SLV);
    pol = s_r.ctrl[sspspi_pkg::SSPSPI_C_POL];
    cke = s_r.stat[sspspi_pkg::SSPSPI_S_CKE];
    late = s_r.stat[sspspi_pkg::SSPSPI_S_PHASE];
    acc = psel && penable;
    wr = acc && pwrite && !s_r.rdy;
    rd = acc && !pwrite && !s_r.rdy;
    done = 1'b0;
    // apb answers one cycle after the access phase starts
    s_nxt.rdy = acc && !s_r.rdy;
    s_nxt.err = 1'b0;
    s_nxt.rd = '0;
    if (rd) begin
      case (paddr)
        sspspi_pkg::SSPSPI_CTRL_OFS: s_nxt.rd = {24'h00_0000, s_r.ctrl};
        sspspi_pkg::SSPSPI_STAT_OFS: s_nxt.rd = {24'h00_0000, s_r.stat};
        sspspi_pkg::SSPSPI_BUF_OFS:  s_nxt.rd = {24'h00_0000, s_r.buf_q};
        sspspi_pkg::SSPSPI_IRQS_OFS: s_nxt.rd = {29'h0000_0000, s_r.ists};
        sspspi_pkg::SSPSPI_IRQM_OFS: s_nxt.rd = {29'h0000_0000, s_r.imsk};
        default:                     s_nxt.err = 1'b1;
      endcase
      // reading the buffer empties it
      if (paddr == sspspi_pkg::SSPSPI_BUF_OFS) s_nxt.stat[sspspi_pkg::SSPSPI_S_FULL] = 1'b0;
      if (paddr == sspspi_pkg::SSPSPI_IRQS_OFS) s_nxt.ists = '0;
    end
    if (wr) begin
      case (paddr)
        sspspi_pkg::SSPSPI_CTRL_OFS: s_nxt.ctrl = pwdata[7:0];  // flags cleared by writing 0
        sspspi_pkg::SSPSPI_STAT_OFS: begin
          s_nxt.stat[sspspi_pkg::SSPSPI_S_PHASE] = pwdata[sspspi_pkg::SSPSPI_S_PHASE];
          s_nxt.stat[sspspi_pkg::SSPSPI_S_CKE] = pwdata[sspspi_pkg::SSPSPI_S_CKE];
        end
        sspspi_pkg::SSPSPI_BUF_OFS: begin
          if (s_r.busy) begin
            s_nxt.ctrl[sspspi_pkg::SSPSPI_C_COLL] = 1'b1;  // write during transfer
            s_nxt.ists[sspspi_pkg::SSPSPI_I_COLL] = 1'b1;
          end else if (en) begin
            s_nxt.sh = pwdata[7:0];
            s_nxt.busy = 1'b1;
            s_nxt.cnt = sspspi_pkg::SSPSPI_BITS;
            s_nxt.phase = 1'b0;
            s_nxt.div = half_of(mode);
            s_nxt.sdo_q = pwdata[7];  // first bit presented before the first edge
          end
        end
        sspspi_pkg::SSPSPI_IRQM_OFS: s_nxt.imsk = pwdata[2:0];
        default: s_nxt.err = 1'b1;
      endcase
    end
    // the data/address flag only means something in two-wire mode; here it stays 0
    s_nxt.stat[sspspi_pkg::SSPSPI_S_DA] = 1'b0;
    s_nxt.sck_d = pin_s[2];
    // between bytes the clock rests at the polarity level, even if it changes while enabled
    if (!s_r.busy) s_nxt.sck_q = pol;
    if (!en) begin
      s_nxt.busy = 1'b0;
      s_nxt.sck_q = pol;
    end else if (master && s_r.busy) begin
      // master: each bit is two halves; the launch edge opens it
      tick = (mode == sspspi_pkg::SSPSPI_M_TMR) ? tmr_match : (s_r.div == 8'h01);
      if (mode != sspspi_pkg::SSPSPI_M_TMR) s_nxt.div = tick ? half_of(mode) : s_r.div - 8'h01;
      if (tick) begin
        if (!s_r.phase) begin
          s_nxt.phase = 1'b1;
          s_nxt.sck_q = ~s_r.sck_q;  // first edge of the bit
          if (!late) s_nxt.samp = pin_s[1];
        end else begin
          s_nxt.phase = 1'b0;
          s_nxt.sck_q = ~s_r.sck_q;
          s_nxt.sh = {s_r.sh[6:0], late ? pin_s[1] : s_r.samp};
          s_nxt.sdo_q = s_r.sh[6];
          s_nxt.cnt = s_r.cnt - 4'h1;
          done = (s_r.cnt == 4'h1);
        end
      end
    end else if (slave && (mode == sspspi_pkg::SSPSPI_M_SLV || !pin_s[0])) begin
      // slave: edge select with polarity picks launch edge; sample opposite
      sck_e = pin_s[2] != s_r.sck_d;
      lead = sck_e && (pin_s[2] != pol);   // leaving idle level
      trail = sck_e && (pin_s[2] == pol);  // returning to idle level
      launch_e = cke ? lead : trail;
      capture_e = cke ? trail : lead;
      // only a leading edge opens a frame; the edge after the last bit must not
      if (!s_r.busy && lead) begin
        s_nxt.busy = 1'b1;
        s_nxt.cnt = sspspi_pkg::SSPSPI_BITS;
      end
      // sample phase must be clear in slave; middle sampling assumed
      if (capture_e) begin
        s_nxt.sh = {s_r.sh[6:0], pin_s[1]};
        s_nxt.cnt = (s_r.busy ? s_r.cnt : sspspi_pkg::SSPSPI_BITS) - 4'h1;
        done = ((s_r.busy ? s_r.cnt : sspspi_pkg::SSPSPI_BITS) == 4'h1);
      end
      if (launch_e && s_r.busy) s_nxt.sdo_q = s_r.sh[7];
    end
    // byte complete: buffer or overflow
    if (done) begin
      s_nxt.busy = 1'b0;
      s_nxt.sck_q = pol;
      s_nxt.ists[sspspi_pkg::SSPSPI_I_DONE] = 1'b1;
      if (s_r.stat[sspspi_pkg::SSPSPI_S_FULL] && slave) begin
        s_nxt.ctrl[sspspi_pkg::SSPSPI_C_OVF] = 1'b1;
        s_nxt.ists[sspspi_pkg::SSPSPI_I_OVF] = 1'b1;  // shift data dropped
      end else begin
        s_nxt.buf_q = s_nxt.sh;
        s_nxt.stat[sspspi_pkg::SSPSPI_S_FULL] = 1'b1;
      end
    end
    s_nxt.irq = |(s_nxt.ists & s_nxt.imsk);
    // pin enables follow the next control word, so they change with the write itself
    s_nxt.sck_en = s_nxt.ctrl[sspspi_pkg::SSPSPI_C_EN] &&
                   (s_nxt.ctrl[3:0] <= sspspi_pkg::SSPSPI_M_TMR);
    s_nxt.sdo_en = s_nxt.ctrl[sspspi_pkg::SSPSPI_C_EN];
  end
  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{ctrl: sspspi_pkg::SSPSPI_CTRL_RST, stat: sspspi_pkg::SSPSPI_STAT_RST,
               ists: sspspi_pkg::SSPSPI_IRQ_RST, imsk: sspspi_pkg::SSPSPI_IRQ_RST,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
  // outputs straight from the state register
  assign prdata  = s_r.rd;
  assign pready  = s_r.rdy;
  assign pslverr = s_r.err;
  assign sck_out = s_r.sck_q;
  assign sck_oe  = s_r.sck_en;
  assign sdo     = s_r.sdo_q;
  assign sdo_oe  = s_r.sdo_en;
  assign irq     = s_r.irq;
endmodule

/* File: verification/sspspi_port_asserts.sv */
// checker for the spi port: apb answer, pin enables, idle clock, status
// assumes a bind to sspspi_port; it sees only that module's ports
`timescale 1ns/1ps
module sspspi_port_asserts (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // clock pin
  input wire logic        sck_out,
  input wire logic        sck_oe,
  // data pin
  input wire logic        sdo_oe
);
  logic       wc;      // control write taken at this edge
  logic       mapped;  // address hits a register
  logic [7:0] ctrl_r;  // control word as software last set it
  assign wc = psel && penable && !pready && pwrite && paddr == sspspi_pkg::SSPSPI_CTRL_OFS;
  assign mapped = paddr inside {sspspi_pkg::SSPSPI_CTRL_OFS, sspspi_pkg::SSPSPI_STAT_OFS,
    sspspi_pkg::SSPSPI_BUF_OFS, sspspi_pkg::SSPSPI_IRQS_OFS, sspspi_pkg::SSPSPI_IRQM_OFS};
  // shadow of the control word, taken on the same edge as the design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_r <= 8'h00;
    else if (wc) ctrl_r <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // access phase still waiting for its answer
  sequence s_take;
    psel && penable && !pready;
  endsequence
  property p_rdy; s_take |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access not answered by one pready pulse");
  property p_err; pready |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("slave error does not match address");
  property p_da;
    pready && !pwrite && paddr == sspspi_pkg::SSPSPI_STAT_OFS |-> !prdata[5];
  endproperty
  a_da: assert property (p_da) else $error("data flag set outside two-wire mode");
  // skip the edge right after a write; the design updates the enable on the write's own edge
  property p_oe; !$past(wc) |-> sck_oe == (ctrl_r[5] && ctrl_r[3:0] < 4'h4); endproperty
  a_oe: assert property (p_oe) else $error("clock enable wrong for mode");
  property p_idle; $rose(sck_oe) |-> ##[1:3] sck_out == ctrl_r[4]; endproperty
  a_idle: assert property (p_idle) else $error("idle clock level wrong");
  // data pin is driven exactly while the port is enabled
  property p_doe; sdo_oe == ctrl_r[5]; endproperty
  a_doe: assert property (p_doe) else $error("data pin enable differs from port enable");
endmodule

/* File: verification/sspspi_peer.sv */
// far-side spi peer: slave to the port's master, or master to its slave
// assumes an idle-low clock and frames far slower than pclk
`timescale 1ns/1ps
module sspspi_peer #(
  parameter logic [7:0] PAT_A = 8'h96,  // shown in the first half of each bit
  parameter logic [7:0] PAT_B = 8'h3c   // shown in the second half
) (
  // pins facing the port
  input  wire logic       sck_out,
  input  wire logic       sck_oe,
  input  wire logic       sdo,
  output logic            sck_in,
  output logic            sdi,
  output logic            ss_n,
  // byte taken from the port's data out
  output logic [7:0]      got
);
  logic [3:0] k;  // clock toggles seen in this frame
  initial begin
    sck_in = 1'b0;
    sdi = PAT_A[7];
    ss_n = 1'b1;
    got = 8'h00;
    k = 4'h0;
  end
  // frame count restarts when the port lets go of the clock
  always @(negedge sck_oe) begin
    k = 4'h0;
    sdi = PAT_A[7];
  end
  // new data on every toggle, so middle and end samples differ
  always @(sck_out) begin
    if (sck_oe) begin
      k = k + 4'h1;
      if (k[0]) got = {got[6:0], sdo};
      sdi = k[0] ? PAT_B[7 - k[3:1]] : PAT_A[7 - k[3:1]];
    end
  end
  // one slave frame, 125 ns a bit, data moves while the clock is low
  task automatic send(input logic [7:0] b);
    ss_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi = b[i];
      #62.5 sck_in = 1'b1;
      #62.5 sck_in = 1'b0;
    end
    #62.5 sdi = ~sdi;
    ss_n = 1'b1;
  endtask
endmodule

/* File: verification/sync_serial_port_spi_regs_bench.sv */
// bench for the spi port: registers, master and slave bytes, overflow
// assumes the package constants and the peer model beside the port
`timescale 1ns/1ps
bind sspspi_port sspspi_port_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_oe(sdo_oe));
module sync_serial_port_spi_regs_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        sck_in, sck_out, sck_oe, sdi, sdo, ss_n, irq;
  logic [7:0]  paddr, got;
  logic [31:0] pwdata, prdata;
  int          failures, num_checks;
  sspspi_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi),
    .sdo(sdo), .sdo_oe(), .ss_n(ss_n), .tmr_match(1'b0), .irq(irq));
  sspspi_peer peer (.sck_out(sck_out), .sck_oe(sck_oe), .sdo(sdo), .sck_in(sck_in),
    .sdi(sdi), .ss_n(ss_n), .got(got));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one apb transfer, held until pready is seen, then an idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) chk(32'h0000_0000, 32'h0000_0001);
    if (pready !== 1'b1) end_sim();
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
  endtask
  // bounded wait for the interrupt line
  task automatic wirq;
    @(posedge pclk);  // realign: a peer frame ends between clock edges
    for (int n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    if (irq !== 1'b1) end_sim();
  endtask
  // reset values, an unmapped place, a brief high idle clock
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rd(sspspi_pkg::SSPSPI_CTRL_OFS, 32'h0000_0000);
    rd(sspspi_pkg::SSPSPI_STAT_OFS, 32'h0000_0000);
    apb(1'b0, 8'hfc, 32'h0000_0000, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    wr(sspspi_pkg::SSPSPI_CTRL_OFS, 32'h0000_0031);
    wr(sspspi_pkg::SSPSPI_CTRL_OFS, 32'h0000_0000);
  endtask
  // master byte; the peer shows other data in each half of a bit
  // second byte lands on an unread buffer and a third write collides with it
  task automatic t_master(input logic late, input logic [31:0] x, input logic [31:0] c);
    wr(sspspi_pkg::SSPSPI_STAT_OFS, {24'h0, late, 7'h0});
    wr(sspspi_pkg::SSPSPI_IRQM_OFS, 32'h0000_0001);
    wr(sspspi_pkg::SSPSPI_CTRL_OFS, c);
    wr(sspspi_pkg::SSPSPI_BUF_OFS, 32'h0000_00a5);
    wirq();
    chk({24'h0, got}, 32'h0000_00a5);
    rd(sspspi_pkg::SSPSPI_IRQS_OFS, 32'h0000_0001);
    wr(sspspi_pkg::SSPSPI_BUF_OFS, 32'h0000_00a5);
    wr(sspspi_pkg::SSPSPI_BUF_OFS, 32'h0000_005a);
    wirq();
    chk({24'h0, got}, 32'h0000_00a5);
    rd(sspspi_pkg::SSPSPI_CTRL_OFS, c | 32'h0000_0080);
    wr(sspspi_pkg::SSPSPI_CTRL_OFS, c);
    rd(sspspi_pkg::SSPSPI_BUF_OFS, x);
    rd(sspspi_pkg::SSPSPI_IRQS_OFS, 32'h0000_0005);
  endtask
  // slave bytes; the second lands unread and is lost
  task automatic t_slave;
    wr(sspspi_pkg::SSPSPI_CTRL_OFS, 32'h0000_0025);
    wr(sspspi_pkg::SSPSPI_STAT_OFS, 32'h0000_0000);
    wr(sspspi_pkg::SSPSPI_IRQM_OFS, 32'h0000_0003);
    peer.send(8'h3c);
    wirq();
    rd(sspspi_pkg::SSPSPI_STAT_OFS, 32'h0000_0001);
    rd(sspspi_pkg::SSPSPI_IRQS_OFS, 32'h0000_0001);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    peer.send(8'h55);
    wirq();
    rd(sspspi_pkg::SSPSPI_CTRL_OFS, 32'h0000_0065);
    rd(sspspi_pkg::SSPSPI_BUF_OFS, 32'h0000_003c);
    wr(sspspi_pkg::SSPSPI_IRQM_OFS, 32'h0000_0000);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(sspspi_pkg::SSPSPI_CTRL_OFS, 32'h0000_0025);
    rd(sspspi_pkg::SSPSPI_CTRL_OFS, 32'h0000_0025);
  endtask
  initial begin
    failures = 0;
    num_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_master(1'b0, 32'h0000_0096, 32'h0000_0021);
    t_master(1'b1, 32'h0000_003c, 32'h0000_0022);
    t_slave();
    end_sim();
  end
endmodule
